// ### logic/clock_divider_align_delay.v
// Divider control: addressing, alignment, cycle swallow and launch edge, AHB-Lite registers
//
// Operation
// - Three strap pins give the unit identity
// - Broadcast enabled also accepts all-ones identity
// - Broadcast bit set per unit by host
// - Broadcast off: all-ones ignored unless strapped so
// - Alignment trigger restarts divider after fixed count
// - Start delay: half ratio plus one or two
// - Swallow trigger blocks exactly one input cycle
// - Launch-edge bit: one rising, zero falling
// - Swallow then edge one-to-zero gives half period
// - Aware trigger pin rising edge starts function
// - Alignment level keeps running; swallow edge-triggered
//
// Implementation choices: the address map and the AHB-Lite slave port.
`include "clock_divider_align_delay_regs.vh"
`timescale 1ns/1ps
`default_nettype none

module clock_divider_align_delay (
  // Clock and reset
  input  wire        clock_in,
  input  wire        rst_n_in,
  // AHB-Lite slave
  input  wire        hsel_in,
  input  wire [31:0] haddr_in,
  input  wire [1:0]  htrans_in,
  input  wire        hwrite_in,
  input  wire [2:0]  hsize_in,
  input  wire        hready_in,
  input  wire [31:0] hwdata_in,
  output reg  [31:0] hrdata_out,
  output reg         hreadyout_out,
  output reg         hresp_out,
  // Pins
  input  wire        identity_strap_bit0_in,
  input  wire        identity_strap_bit1_in,
  input  wire        identity_strap_bit2_in,
  input  wire        external_trigger_pin_in,
  // Divided output
  output reg         divider_out
);

  wire [2:0] strap_id;
  wire       external_trigger_pin_pin_s;

  reg        wr_pend_r;
  reg [3:0]  wr_idx_r;
  reg [2:0]  ratio_code_r;
  reg        broadcast_r;
  reg        sync_aware_r;
  reg        slip_aware_r;
  reg        launch_edge_r;
  reg        launch_prev_r;
  reg        sync_run_r;
  reg        sync_run_prev_r;
  reg        slip_req_r;
  reg        slip_prev_r;
  reg        external_trigger_pin_prev_r;
  reg        running_r;
  reg        disabled_r;
  reg [4:0]  wait_r;
  reg [4:0]  cnt_r;
  reg [4:0]  cnt_nxt;
  reg [4:0]  half;
  reg [4:0]  start_cnt;
  reg [31:0] read_nxt;

  wire [2:0] frame_id  = hwdata_in[`FRAME_ID_MSB:`FRAME_ID_LSB];
  wire       id_ok     = (frame_id == strap_id) ||
                         ((frame_id == `BROADCAST_ID) && broadcast_r);
  wire       commit    = wr_pend_r && id_ok;
  wire       pin_rise  = external_trigger_pin_pin_s && !external_trigger_pin_prev_r;
  wire       sync_external_trigger_pin = (sync_run_r && !sync_run_prev_r) ||
                         (sync_aware_r && pin_rise);
  wire       slip_external_trigger_pin = (slip_req_r && !slip_prev_r) ||
                         (slip_aware_r && pin_rise);
  wire       hold      = !sync_run_r && !sync_aware_r;
  wire       advance   = launch_prev_r && !launch_edge_r;
  wire       addr_ph   = hsel_in && htrans_in[1] && hready_in;

  // Straps and trigger pin come from outside the clock domain
  pin_synchronizer #(
    .WIDTH (3)
  ) u_strap_sync (
    .clock_in (clock_in),
    .rst_n_in (rst_n_in),
    .async_in ({identity_strap_bit2_in, identity_strap_bit1_in, identity_strap_bit0_in}),
    .sync_out (strap_id)
  );

  pin_synchronizer #(
    .WIDTH (1)
  ) u_external_trigger_pin_sync (
    .clock_in (clock_in),
    .rst_n_in (rst_n_in),
    .async_in (external_trigger_pin_in),
    .sync_out (external_trigger_pin_pin_s)
  );

  // Half ratio and alignment start count
  always @*
  begin
    if (ratio_code_r == 3'h0)
      half = 5'h01;
    else if (ratio_code_r > `RATIO_CODE_MAX)
      half = 5'h10;
    else
      half = 5'h01 << (ratio_code_r - 3'h1);
    start_cnt = half + (launch_edge_r ? `SYNC_EXTRA_RISE : `SYNC_EXTRA_FALL);
  end

  // Read mux
  always @*
  begin
    read_nxt = 32'h0000_0000;
    case (haddr_in[5:2])
      `RATIO_REG_IDX:   read_nxt[2:0] = ratio_code_r;
      `OPTION_REG_IDX:  read_nxt[2:0] = {slip_aware_r, sync_aware_r, broadcast_r};
      `PHASE_REG_IDX:   read_nxt[`LAUNCH_EDGE_BIT] = launch_edge_r;
      `TRIGGER_REG_IDX: read_nxt[1:0] = {slip_req_r, sync_run_r};
      `STATUS_REG_IDX:  read_nxt[5:0] = {disabled_r, divider_out, running_r, strap_id};
      default:          read_nxt = 32'h0000_0000;
    endcase
    if (haddr_in[31:6] != 26'h0 || haddr_in[1:0] != 2'h0)
      read_nxt = 32'h0000_0000;
  end

  // Bus slave and registers
  always @(posedge clock_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      hrdata_out    <= 32'h0000_0000;
      hreadyout_out <= 1'b1;
      hresp_out     <= 1'b0;
      wr_pend_r     <= 1'b0;
      wr_idx_r      <= 4'h0;
      ratio_code_r  <= `RATIO_CODE_RESET;
      broadcast_r   <= 1'b0;
      sync_aware_r  <= 1'b0;
      slip_aware_r  <= 1'b0;
      launch_edge_r <= `LAUNCH_EDGE_RESET;
      sync_run_r    <= `SYNC_RUN_RESET;
      slip_req_r    <= `SLIP_REQ_RESET;
    end
    else
    begin
      hreadyout_out <= 1'b1;
      hresp_out     <= 1'b0;
      if (hready_in)
      begin
        wr_pend_r <= addr_ph && hwrite_in && (haddr_in[31:6] == 26'h0);
        wr_idx_r  <= haddr_in[5:2];
      end
      if (addr_ph && !hwrite_in)
        hrdata_out <= read_nxt;
      if (commit)
      begin
        case (wr_idx_r)
          `RATIO_REG_IDX:
            ratio_code_r <= hwdata_in[`RATIO_CODE_MSB:0];
          `OPTION_REG_IDX:
          begin
            broadcast_r  <= hwdata_in[`BROADCAST_BIT];
            sync_aware_r <= hwdata_in[`SYNC_PIN_AWARE_BIT];
            slip_aware_r <= hwdata_in[`SLIP_PIN_AWARE_BIT];
          end
          `PHASE_REG_IDX:
            launch_edge_r <= hwdata_in[`LAUNCH_EDGE_BIT];
          `TRIGGER_REG_IDX:
          begin
            sync_run_r <= hwdata_in[`SYNC_RUN_BIT];
            slip_req_r <= hwdata_in[`SLIP_REQ_BIT];
          end
          default:
            wr_pend_r <= 1'b0;
        endcase
      end
    end
  end

  // Counter step; swallow blocks one cycle, edge change from one to zero advances one
  always @*
  begin
    cnt_nxt = cnt_r + (advance ? 5'h02 : 5'h01);
  end

  // Divider core
  always @(posedge clock_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      launch_prev_r   <= `LAUNCH_EDGE_RESET;
      sync_run_prev_r <= `SYNC_RUN_RESET;
      slip_prev_r     <= `SLIP_REQ_RESET;
      external_trigger_pin_prev_r     <= 1'b0;
      running_r       <= 1'b1;
      disabled_r      <= 1'b0;
      wait_r          <= 5'h00;
      cnt_r           <= 5'h00;
      divider_out     <= 1'b0;
    end
    else
    begin
      launch_prev_r   <= launch_edge_r;
      sync_run_prev_r <= sync_run_r;
      slip_prev_r     <= slip_req_r;
      external_trigger_pin_prev_r     <= external_trigger_pin_pin_s;
      if (sync_external_trigger_pin)
      begin
        divider_out <= 1'b0;
        running_r   <= 1'b0;
        cnt_r       <= 5'h00;
        wait_r      <= start_cnt;
        disabled_r  <= (ratio_code_r == 3'h0);
      end
      else if (wait_r != 5'h00)
      begin
        wait_r <= wait_r - 5'h01;
        if (wait_r == 5'h01 && !disabled_r)
        begin
          divider_out <= 1'b1;
          running_r   <= 1'b1;
        end
      end
      else if (running_r && !hold && !slip_external_trigger_pin)
      begin
        if (cnt_nxt >= half)
        begin
          divider_out <= ~divider_out;
          cnt_r       <= cnt_nxt - half;
        end
        else
          cnt_r <= cnt_nxt;
      end
    end
  end

endmodule
`default_nettype wire

// ### logic/clock_divider_align_delay_regs.vh
// Register offsets, field positions, reset values and timing figures of the divider block
`ifndef CLOCK_DIVIDER_ALIGN_DELAY_REGS_VH
`define CLOCK_DIVIDER_ALIGN_DELAY_REGS_VH

// Register indices; byte address is four times the index
`define RATIO_REG_IDX      4'h2
`define OPTION_REG_IDX     4'h4
`define PHASE_REG_IDX      4'h6
`define TRIGGER_REG_IDX    4'hd
`define STATUS_REG_IDX     4'he

// Field positions
`define RATIO_CODE_MSB     2
`define BROADCAST_BIT      0
`define SYNC_PIN_AWARE_BIT 1
`define SLIP_PIN_AWARE_BIT 2
`define LAUNCH_EDGE_BIT    2
`define SYNC_RUN_BIT       0
`define SLIP_REQ_BIT       1
`define FRAME_ID_MSB       31
`define FRAME_ID_LSB       29

// Reset values
`define RATIO_CODE_RESET   3'h1
`define OPTION_RESET       3'h0
`define LAUNCH_EDGE_RESET  1'h1
`define SYNC_RUN_RESET     1'h1
`define SLIP_REQ_RESET     1'h0

// Identity and ratio figures
`define BROADCAST_ID       3'h7
`define RATIO_CODE_MAX     3'h5
`define SYNC_EXTRA_FALL    5'h01
`define SYNC_EXTRA_RISE    5'h02

`endif

// ### logic/pin_synchronizer.v
// Two flip-flop synchroniser for asynchronous pin inputs
`timescale 1ns/1ps
`default_nettype none

module pin_synchronizer #(
  parameter WIDTH = 1
) (
  // Clock and reset
  input  wire             clock_in,
  input  wire             rst_n_in,
  // Pin side
  input  wire [WIDTH-1:0] async_in,
  // Clock domain side
  output reg  [WIDTH-1:0] sync_out
);

  reg [WIDTH-1:0] stage1_r;

  always @(posedge clock_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      stage1_r <= {WIDTH{1'b0}};
      sync_out <= {WIDTH{1'b0}};
    end
    else
    begin
      stage1_r <= async_in;
      sync_out <= stage1_r;
    end
  end

endmodule
`default_nettype wire

// ### sim/bus_host.sv
// Bus host model: single-word AHB-Lite transfers
`timescale 1ns/1ps
`default_nettype none
module bus_host (
  input  wire logic        clock_in,
  input  wire logic        hready_in,
  input  wire logic [31:0] hrdata_in,
  output var logic         hsel_out,
  output var logic [31:0]  haddr_out,
  output var logic [1:0]   htrans_out,
  output var logic         hwrite_out,
  output var logic [2:0]   hsize_out,
  output var logic [31:0]  hwdata_out
);
  initial
  begin
    hsel_out = 1'b0;
    haddr_out = 32'h0;
    htrans_out = 2'h0;
    hwrite_out = 1'b0;
    hsize_out = 3'h0;
    hwdata_out = 32'h0;
  end
  task automatic xfer(input logic w, input logic [3:0] idx, input logic [31:0] wd,
                      output logic [31:0] rd);
    hsel_out <= 1'b1;
    htrans_out <= 2'h2;
    haddr_out <= {26'h0, idx, 2'h0};
    hwrite_out <= w;
    hsize_out <= 3'h2;
    do @(posedge clock_in); while (hready_in !== 1'b1);
    htrans_out <= 2'h0;
    hwdata_out <= w ? wd : ~hwdata_out;
    do @(posedge clock_in); while (hready_in !== 1'b1);
    rd = hrdata_in;
  endtask
endmodule
`default_nettype wire

// ### sim/clock_divider_align_delay_test.sv
// Self-checking bench for the divider control block
`timescale 1ns/1ps
`default_nettype none
`include "clock_divider_align_delay_regs.vh"
module clock_divider_align_delay_test;
  localparam logic [2:0] OWN_ID = 3'h5;
  logic        clock_in = 1'b0;
  logic        rst_n_in = 1'b0;
  logic        external_trigger_pin = 1'b0;
  logic        hsel, hwrite, ready, dout, resp;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [31:0] haddr, hwdata, hrdata;
  int          n_errors = 0;
  int          checks = 0;
  always #50 clock_in = ~clock_in;
  clock_divider_align_delay DUT (.clock_in(clock_in), .rst_n_in(rst_n_in), .hsel_in(hsel),
    .haddr_in(haddr), .htrans_in(htrans), .hwrite_in(hwrite), .hsize_in(hsize),
    .hready_in(ready), .hwdata_in(hwdata), .hrdata_out(hrdata), .hreadyout_out(ready),
    .hresp_out(resp), .identity_strap_bit0_in(OWN_ID[0]), .identity_strap_bit1_in(OWN_ID[1]),
    .identity_strap_bit2_in(OWN_ID[2]), .external_trigger_pin_in(external_trigger_pin), .divider_out(dout));
  bus_host host (.clock_in(clock_in), .hready_in(ready), .hrdata_in(hrdata), .hsel_out(hsel),
    .haddr_out(haddr), .htrans_out(htrans), .hwrite_out(hwrite), .hsize_out(hsize),
    .hwdata_out(hwdata));
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wr(input logic [2:0] id, input logic [3:0] idx, input logic [2:0] v);
    logic [31:0] d;
    host.xfer(1'b1, idx, {id, 26'h0, v}, d);
  endtask
  task automatic rd(input logic [3:0] idx, input logic [31:0] exp, input string what);
    logic [31:0] d;
    host.xfer(1'b0, idx, 32'h0, d);
    chk(what, d, exp);
  endtask
  task automatic rise(output int n);
    for (n = 0; dout !== 1'b0; n++) @(posedge clock_in);
    for (n = n; dout !== 1'b1; n++) @(posedge clock_in);
  endtask
  task automatic sync;
    wr(3'h7, `TRIGGER_REG_IDX, 3'h0);
    wr(3'h7, `TRIGGER_REG_IDX, 3'h1);
  endtask
  task automatic t_regs;
    logic [31:0] d;
    rd(`RATIO_REG_IDX, 32'h1, "ratio");
    rd(`OPTION_REG_IDX, 32'h0, "options");
    rd(`PHASE_REG_IDX, 32'h4, "phase");
    rd(`TRIGGER_REG_IDX, 32'h1, "trigger");
    rd(4'h0, 32'h0, "unmapped");
    // Output bit toggles freely after reset; running bit is set
    host.xfer(1'b0, `STATUS_REG_IDX, 32'h0, d);
    chk("strap id", d & 32'h0000_002f, 32'h8 | OWN_ID);
  endtask
  task automatic t_address;
    wr(3'h3, `RATIO_REG_IDX, 3'h4);
    wr(3'h7, `RATIO_REG_IDX, 3'h4);
    rd(`RATIO_REG_IDX, 32'h1, "foreign id");
    wr(OWN_ID, `OPTION_REG_IDX, 3'h1);
    wr(3'h7, `RATIO_REG_IDX, 3'h2);
    rd(`RATIO_REG_IDX, 32'h2, "broadcast");
  endtask
  task automatic t_sync;
    int n1, n0, w;
    sync();
    rise(n1);
    wr(3'h7, `PHASE_REG_IDX, 3'h0);
    sync();
    rise(n0);
    chk("start step", n1 - n0, 32'h1);
    for (w = 0; dout === 1'b1; w++) @(posedge clock_in);
    chk("high width", w, 32'h2);
    wr(3'h7, `PHASE_REG_IDX, 3'h4);
    sync();
  endtask
  task automatic t_slip;
    int a, b;
    rise(a);
    wr(3'h7, `TRIGGER_REG_IDX, 3'h3);
    rise(a);
    rise(b);
    chk("slip span", a + b + 2, 32'h9);
    wr(3'h7, `TRIGGER_REG_IDX, 3'h1);
    rise(a);
    wr(3'h7, `PHASE_REG_IDX, 3'h0);
    rise(a);
    rise(b);
    chk("edge span", a + b + 2, 32'h7);
  endtask
  task automatic pulse(output int n);
    external_trigger_pin <= 1'b1;
    repeat (3) @(posedge clock_in);
    external_trigger_pin <= 1'b0;
    repeat (2) @(posedge clock_in);
    rise(n);
  endtask
  task automatic t_pin;
    int d1, d2;
    wr(OWN_ID, `OPTION_REG_IDX, 3'h3);
    rise(d1);
    pulse(d1);
    rise(d2);
    @(posedge clock_in);
    pulse(d2);
    chk("pin restart", d1, d2);
    chk("pin start", d1, 32'h2);
  endtask
  task automatic t_bypass;
    wr(3'h7, `RATIO_REG_IDX, 3'h0);
    sync();
    repeat (4) @(posedge clock_in);
    rd(`STATUS_REG_IDX, 32'h20 | OWN_ID, "bypass status");
  endtask
  task automatic conclude;
    $display("checks %0d errors %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  initial
  begin
    repeat (8) @(posedge clock_in);
    rst_n_in <= 1'b1;
    repeat (3) @(posedge clock_in);
    t_regs();
    t_address();
    t_sync();
    t_slip();
    t_pin();
    t_bypass();
    conclude();
  end
  initial
  begin
    repeat (3000) @(posedge clock_in);
    n_errors++;
    conclude();
  end
endmodule
bind clock_divider_align_delay divider_props chk_i (
  .clock_in      (clock_in),
  .rst_n_in      (rst_n_in),
  .hsel_in       (hsel_in),
  .haddr_in      (haddr_in),
  .htrans_in     (htrans_in),
  .hwrite_in     (hwrite_in),
  .hready_in     (hready_in),
  .hrdata_out    (hrdata_out),
  .hreadyout_out (hreadyout_out),
  .hresp_out     (hresp_out),
  .divider_out   (divider_out)
);
`default_nettype wire

// ### sim/divider_props.sv
// Checker of bus and status behaviour of the divider block
`timescale 1ns/1ps
`default_nettype none
module divider_props (
  input wire logic        clock_in,
  input wire logic        rst_n_in,
  input wire logic        hsel_in,
  input wire logic [31:0] haddr_in,
  input wire logic [1:0]  htrans_in,
  input wire logic        hwrite_in,
  input wire logic        hready_in,
  input wire logic [31:0] hrdata_out,
  input wire logic        hreadyout_out,
  input wire logic        hresp_out,
  input wire logic        divider_out
);
  default clocking @(posedge clock_in); endclocking
  default disable iff (!rst_n_in);
  wire rd = hsel_in && htrans_in[1] && hready_in && !hwrite_in;
  ready_high_a: assert property (hreadyout_out) else $error("not ready");
  resp_okay_a: assert property (!hresp_out) else $error("error response");
  rdata_hold_a: assert property (!rd |=> $stable(hrdata_out)) else $error("read data moved");
  unmapped_zero_a: assert property (rd && haddr_in == 32'h0 |=> hrdata_out == 32'h0)
    else $error("unmapped read not zero");
  ratio_field_a: assert property (rd && haddr_in == 32'h8 |=> hrdata_out[31:3] == 29'h0)
    else $error("ratio upper bits set");
  option_field_a: assert property (rd && haddr_in == 32'h10 |=> hrdata_out[31:3] == 29'h0)
    else $error("option upper bits set");
  phase_field_a: assert property (rd && haddr_in == 32'h18 |=> (hrdata_out & 32'hfffffffb) == 0)
    else $error("phase stray bits set");
  status_out_a: assert property (rd && haddr_in == 32'h38 |=> hrdata_out[4] == $past(divider_out))
    else $error("status output bit wrong");
  status_read_c: cover property (rd && haddr_in == 32'h38);
  output_rise_c: cover property ($rose(divider_out));
  bus_write_c: cover property (hsel_in && htrans_in[1] && hwrite_in);
endmodule
`default_nettype wire
